//--- rtl/ehsp_pkg.sv
`default_nettype none
package ehsp_pkg;
   // Framing widths.
   localparam int unsigned BYTE_BITS = 8;
   localparam int unsigned UNIT3_BITS = 9;
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [3:0] LAST_BIT4 = 4'h7;
   localparam logic [3:0] LAST_BIT3 = 4'h8;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   // Pin levels held by the synchronisers in reset: select high, clock low, reset pin high.
   localparam logic [4:0] PIN_IDLE = 5'h11;
   // Link clock sampling.
   localparam real CLK_PERIOD_NS = 20.0;
   localparam real LINK_PERIOD_NS = 160.0;

   // Received byte with its kind.
   typedef struct packed {
      logic is_data;
      logic [7:0] value;
   } ehsp_byte_t;

   // Framing modes chosen by the strap.
   typedef enum logic {
      EHSP_FOUR_LINE,
      EHSP_THREE_LINE
   } ehsp_mode_t;

   // Receive states.
   typedef enum logic [1:0] {
      EHSP_IDLE,
      EHSP_FLAG,
      EHSP_BITS
   } ehsp_state_t;
endpackage
`default_nettype wire

//--- rtl/ehsp_port.sv
`default_nettype none
// Summary of operation
// - Serial activity accepted only while select low.
// - D/C line high (flag bit high in 3-line) marks received byte as data.
// - D/C line low (flag bit low in 3-line) marks received byte as command.
// - Active-low hard reset returns the receive and read logic to idle.
// - Busy high while waveform output runs.
// - Busy high during temperature sensor exchange.
// - Strap low selects 4-line framing.
// - Strap high selects 9-bit 3-line framing.
// - 4-line bytes sampled rising edge, MSB first.
// - 3-line unit: flag bit then bits 7..0.
// - Read bytes shift out MSB first, falling edges.
module ehsp_port
   import ehsp_pkg::*;
(
   // Clock and resets.
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   input wire logic hard_reset_in_n,
   // Serial pins.
   input wire logic cs_n_in,
   input wire logic dc_in,
   input wire logic sclk_in,
   input wire logic sdi_in,
   input wire logic bus_width_strap_in,
   output logic sdo_out,
   output logic sdo_oe_out,
   // Core side.
   output ehsp_byte_t rx_byte_out,
   output logic rx_valid_out,
   input wire logic [7:0] tx_byte_in,
   input wire logic tx_load_in,
   input wire logic waveform_active_in,
   input wire logic sensor_active_in,
   output logic busy_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers: two flops per pin before any logic looks at it.
   logic [4:0] sync1_reg;
   logic [4:0] sync2_reg;
   logic sclk_prev_reg;
   logic hard_rst_sync1_reg;
   logic hard_rst_sync2_reg;
   logic strap_reg;

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         // The serial clock idles low, so no false edge follows reset.
         sync1_reg <= PIN_IDLE;
         sync2_reg <= PIN_IDLE;
      end else begin
         sync1_reg <= {cs_n_in, dc_in, sclk_in, sdi_in, hard_reset_in_n};
         sync2_reg <= sync1_reg;
      end
   end

   wire logic cs_n_s = sync2_reg[4];
   wire logic dc_s = sync2_reg[3];
   wire logic sclk_s = sync2_reg[2];
   wire logic sdi_s = sync2_reg[1];
   wire logic hard_n_s = sync2_reg[0];

   // The edge detector works on the second stage only.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sclk_prev_reg <= 1'b0;
      end else begin
         sclk_prev_reg <= sclk_s;
      end
   end

   wire logic sclk_rise = sclk_s & ~sclk_prev_reg;
   wire logic sclk_fall = ~sclk_s & sclk_prev_reg;
   // Logic reset is the synchronised reset pin alone, inverted; the system reset acts separately.
   wire logic soft_rst = ~hard_n_s;

   ////////////////////////////////////////////////////////////////////////////
   // Strap followed while reset pin is low or select is high, held while a frame is selected.
   logic strap_s1_reg;
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         strap_s1_reg <= 1'b0;
         strap_reg <= 1'b0;
      end else begin
         strap_s1_reg <= bus_width_strap_in;
         if (soft_rst || cs_n_s) begin
            strap_reg <= strap_s1_reg;
         end
      end
   end

   wire ehsp_mode_t mode = strap_reg ? EHSP_THREE_LINE : EHSP_FOUR_LINE;

   ////////////////////////////////////////////////////////////////////////////
   // Receive shifter.
   ehsp_state_t state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] shift_reg;
   logic flag_reg;

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg <= EHSP_IDLE;
         bit_cnt_reg <= CNT_ZERO;
         shift_reg <= BYTE_ZERO;
         flag_reg <= 1'b0;
      end else if (soft_rst || cs_n_s) begin
         state_reg <= EHSP_IDLE;
         bit_cnt_reg <= CNT_ZERO;
      end else begin
         unique case (state_reg)
            EHSP_IDLE: begin
               state_reg <= (mode == EHSP_THREE_LINE) ? EHSP_FLAG : EHSP_BITS;
               bit_cnt_reg <= CNT_ZERO;
            end
            EHSP_FLAG: begin
               if (sclk_rise) begin
                  flag_reg <= sdi_s;
                  state_reg <= EHSP_BITS;
               end
            end
            EHSP_BITS: begin
               if (sclk_rise) begin
                  shift_reg <= {shift_reg[6:0], sdi_s};
                  if (mode == EHSP_FOUR_LINE) begin
                     flag_reg <= dc_s;
                  end
                  if (bit_cnt_reg == LAST_BIT4) begin
                     bit_cnt_reg <= CNT_ZERO;
                     state_reg <= (mode == EHSP_THREE_LINE) ? EHSP_FLAG : EHSP_BITS;
                  end else begin
                     bit_cnt_reg <= bit_cnt_reg + CNT_ONE;
                  end
               end
            end
            default: state_reg <= EHSP_IDLE;
         endcase
      end
   end

   wire logic byte_done = !cs_n_s && !soft_rst && state_reg == EHSP_BITS
                          && sclk_rise && bit_cnt_reg == LAST_BIT4;

   // Completed byte presented with its kind for one cycle.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rx_byte_out <= '0;
         rx_valid_out <= 1'b0;
      end else begin
         rx_valid_out <= byte_done;
         if (byte_done) begin
            rx_byte_out.value <= {shift_reg[6:0], sdi_s};
            rx_byte_out.is_data <= (mode == EHSP_FOUR_LINE) ? dc_s : flag_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read shifter: loaded by the core, one bit per falling edge.
   logic [7:0] tx_shift_reg;
   logic tx_active_reg;
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tx_shift_reg <= BYTE_ZERO;
         tx_active_reg <= 1'b0;
         sdo_out <= 1'b0;
      end else if (soft_rst || cs_n_s) begin
         tx_active_reg <= 1'b0;
         sdo_out <= 1'b0;
      end else if (tx_load_in) begin
         // The first bit must stand before the host's first rising edge.
         sdo_out <= tx_byte_in[7];
         tx_shift_reg <= {tx_byte_in[6:0], 1'b0};
         tx_active_reg <= 1'b1;
      end else if (tx_active_reg && sclk_fall) begin
         sdo_out <= tx_shift_reg[7];
         tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
      end
   end
   assign sdo_oe_out = tx_active_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Busy follows the core's activity.
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         busy_out <= 1'b0;
      end else begin
         busy_out <= waveform_active_in | sensor_active_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   sequence s_busy_cause;
      waveform_active_in || sensor_active_in;
   endsequence

   AST_BUSY_SET: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      s_busy_cause |=> busy_out) else $error("busy not raised");
   AST_BUSY_CLR: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      !(waveform_active_in || sensor_active_in) |=> !busy_out) else $error("busy not dropped");
   AST_SENSOR_BUSY: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      sensor_active_in |=> busy_out) else $error("busy low in sensor exchange");
   AST_CS_IGNORE: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      cs_n_s |=> !rx_valid_out) else $error("byte taken with select high");
   AST_HARD_RST: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      soft_rst |=> state_reg == EHSP_IDLE && !rx_valid_out) else $error("logic not reset");
   AST_DATA_KIND: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      byte_done && mode == EHSP_FOUR_LINE && dc_s |=> rx_byte_out.is_data) else $error("data kind lost");
   AST_CMD_KIND: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      byte_done && mode == EHSP_FOUR_LINE && !dc_s |=> !rx_byte_out.is_data) else $error("cmd kind lost");
   AST_FLAG_KIND: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      byte_done && mode == EHSP_THREE_LINE |=> rx_byte_out.is_data == $past(flag_reg)) else $error("flag lost");
   AST_MSB_FIRST: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      byte_done |=> rx_byte_out.value[0] == $past(sdi_s)) else $error("bit order wrong");
   AST_TX_SHIFT: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
      tx_active_reg && sclk_fall && !tx_load_in && !cs_n_s && !soft_rst
      |=> sdo_out == $past(tx_shift_reg[7])) else $error("read bit wrong");
endmodule
`default_nettype wire

//--- tb/ehsp_host_model.sv
`default_nettype none
// Host side of the serial port; write rate 160 ns, read rate 400 ns.
module ehsp_host_model (
   // Clock and status.
   input wire logic clk_in,
   input wire logic busy_in,
   input wire logic sdo_in,
   // Serial pins.
   output logic cs_n_out,
   output logic dc_out,
   output logic sclk_out,
   output logic sdi_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // Serial clock rests low between frames.
   initial begin
      cs_n_out = 1'b1;
      dc_out = 1'b0;
      sclk_out = 1'b0;
      sdi_out = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   // Drives one bit and samples the returned bit before the rise.
   task automatic clk_bit(input logic b, input int half, output logic r);
      sdi_out <= b;
      tick(half);
      r = sdo_in;
      sclk_out <= 1'b1;
      tick(half);
      sclk_out <= 1'b0;
   endtask
   // One unit; the 3-line flag bit goes first and D/C stays low.
   task automatic write_unit(input logic three, sel, isd, input logic [7:0] v, input logic hold);
      logic r;
      while (busy_in !== 1'b0) tick(1);
      cs_n_out <= ~sel;
      dc_out <= three ? 1'b0 : isd;
      tick(4);
      if (three) clk_bit(isd, 4, r);
      for (int i = 7; i >= 0; i--) clk_bit(v[i], 4, r);
      sdi_out <= ~v[0];
      tick(4);
      if (!hold) cs_n_out <= 1'b1;
      tick(4);
   endtask
   // Reads a byte after a held command, then ends the frame.
   task automatic read_byte(output logic [7:0] v);
      dc_out <= 1'b1;
      for (int i = 7; i >= 0; i--) clk_bit(i[0], 10, v[i]);
      tick(4);
      cs_n_out <= 1'b1;
      dc_out <= 1'b0;
      tick(6);
   endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`default_nettype none
module tb_top;
   import ehsp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk, reset_n, hrst_n, cs_n, dc, sclk, sdi, strap, sdo, oe, rx_valid, tx_load, wave, sens, busy;
   logic [7:0] tx_byte, rd;
   logic [31:0] x, seed = 32'hEF97;
   ehsp_byte_t rx_byte, got;
   int n_errors = 0, check_count = 0, n_rx = 0, n0;
   ehsp_port ehsp_port_i (.ref_clk_in(ref_clk), .reset_n_in(reset_n), .hard_reset_in_n(hrst_n),
      .cs_n_in(cs_n), .dc_in(dc), .sclk_in(sclk), .sdi_in(sdi), .bus_width_strap_in(strap),
      .sdo_out(sdo), .sdo_oe_out(oe), .rx_byte_out(rx_byte), .rx_valid_out(rx_valid),
      .tx_byte_in(tx_byte), .tx_load_in(tx_load), .waveform_active_in(wave),
      .sensor_active_in(sens), .busy_out(busy));
   ehsp_host_model host_i (.clk_in(ref_clk), .busy_in(busy), .sdo_in(sdo), .cs_n_out(cs_n),
      .dc_out(dc), .sclk_out(sclk), .sdi_out(sdi));
   // Reference clock at 50 MHz.
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end
   // Collects every received unit.
   always @(posedge ref_clk) if (rx_valid === 1'b1) begin
      got = rx_byte;
      n_rx++;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk_byte(input ehsp_byte_t g, e, input string m);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, e, input string m);
      chk_byte({8'h00, g}, {8'h00, e}, m);
   endtask
   // Sends one unit and checks what arrives.
   task automatic send(input logic three, isd, input logic [7:0] v, input logic sel);
      n0 = n_rx;
      strap <= three;
      repeat (4) @(posedge ref_clk);
      host_i.write_unit(three, sel, isd, v, 1'b0);
      chk_bit(n_rx == n0 + int'(sel && hrst_n), 1'b1, "unit count");
      if (sel && hrst_n) chk_byte(got, {isd, v}, "unit byte");
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Main sequence.
   initial begin
      {reset_n, strap, tx_load, wave, sens, tx_byte} = '0;
      hrst_n = 1'b1;
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      for (int k = 0; k < 16; k++) begin
         x = rnd();
         if (k < 4) x[9:0] = {k[1:0], {8{k[0]}}};
         send(x[9], x[8], x[7:0], 1'b1);
      end
      $display("writes done");
      send(1'b0, 1'b1, 8'h3C, 1'b0);
      hrst_n <= 1'b0;
      send(1'b0, 1'b1, 8'hA5, 1'b1);
      hrst_n <= 1'b1;
      send(1'b1, 1'b0, 8'h5A, 1'b1);
      $display("select and reset done");
      strap <= 1'b0;
      repeat (4) @(posedge ref_clk);
      for (int k = 0; k < 3; k++) begin
         x = rnd();
         host_i.write_unit(1'b0, 1'b1, 1'b0, 8'h2F, 1'b1);
         tx_byte <= x[7:0];
         tx_load <= 1'b1;
         @(posedge ref_clk);
         tx_load <= 1'b0;
         repeat (2) @(posedge ref_clk);
         chk_bit(oe, 1'b1, "read enable");
         host_i.read_byte(rd);
         chk_byte({1'b0, rd}, {1'b0, x[7:0]}, "read byte");
      end
      $display("reads done");
      for (int k = 0; k < 8; k++) begin
         x = rnd();
         wave <= x[0];
         sens <= x[1];
         repeat (3) @(posedge ref_clk);
         chk_bit(busy, x[0] | x[1], "busy level");
      end
      // The host must hold off while busy stands high.
      wave <= 1'b1;
      sens <= 1'b0;
      fork
         begin
            repeat (40) @(posedge ref_clk);
            chk_bit(cs_n, 1'b1, "held off while busy");
            wave <= 1'b0;
         end
         send(1'b0, 1'b0, 8'h12, 1'b1);
      join
      $display("busy done");
      close_out();
   end
   // Watchdog well past the expected run of about 2,500 cycles.
   initial begin
      #1000000;
      n_errors++;
      $display("CHECK FAILED at %0t: watchdog", $time);
      close_out();
   end
endmodule
`default_nettype wire
